// *** bdm_pkg.sv ***
// constants for the banked data memory and flag register block
// Functional notes
// - addresses 00H-7FH are special registers, 80H-FFH general RAM, all 8 bits.
// - eight RAM banks at 80H-FFH each, 1024 bytes in total.
// - special registers same in all banks; nvm control at 40H only in bank 1.
// - indirect port access goes to the address in its pointer; port stores nothing.
// - port 0 reaches bank 0 only; port 1 reaches the selected bank.
// - indirect access to an indirect port reads 00H, write does nothing.
// - bank-select low three bits choose bank 0 to 7 as binary.
// - any reset selects bank 0, except watchdog reset during power down.
// - direct addressing always hits bank 0; banks 1-7 only via port 1.
// - bank-select bits 7-3 read zero; select bits reset to zero.
// - writing pc low jumps within current page and inserts one dummy cycle.
// - table read puts high byte in table-high register, low byte to destination.
// - writes to flag register change arithmetic flags, not watchdog/power-down flags.
// - watchdog flag set by time-out, cleared by power-up, kick or halt.
// - power-down flag set by halt, cleared by power-up or kick.
// - carry set on add carry or no subtract borrow; rotate updates it.
// - auxiliary carry set on low nibble carry or no nibble borrow.
// - zero flag set when arithmetic or logic result is zero.
// - signed-wrap flag set when carry into msb differs from carry out.
// - flag bits 7-6 read zero; watchdog and power-down flags reset to zero.
// - flag register is never saved automatically on interrupt or call.
// - no direct register-to-register move; data passes the working register.
package bdm_pkg;
   // ***************************************************************
   // widths
   // ***************************************************************
   localparam int unsigned DATA_W = 8;
   localparam int unsigned BANK_W = 3;
   localparam int unsigned RAM_AW = 10;
   localparam int unsigned RAM_DEPTH = 1024;
   // ***************************************************************
   // special register addresses
   // ***************************************************************
   localparam logic [7:0] ADDR_IND_PORT_0 = 8'h00;
   localparam logic [7:0] ADDR_IND_PTR_0 = 8'h01;
   localparam logic [7:0] ADDR_IND_PORT_1 = 8'h02;
   localparam logic [7:0] ADDR_IND_PTR_1 = 8'h03;
   localparam logic [7:0] ADDR_BANK_SELECT = 8'h04;
   localparam logic [7:0] ADDR_PROG_CNT_LOW = 8'h06;
   localparam logic [7:0] ADDR_TABLE_HIGH = 8'h09;
   localparam logic [7:0] ADDR_FLAGS = 8'h0A;
   localparam logic [7:0] ADDR_NVM_CONTROL = 8'h40;
   localparam logic [2:0] NVM_BANK = 3'h1;
   localparam logic [2:0] BANK_ZERO = 3'h0;
   // ***************************************************************
   // flag register fields
   // ***************************************************************
   localparam int unsigned FLG_C = 0;
   localparam int unsigned FLG_AC = 1;
   localparam int unsigned FLG_Z = 2;
   localparam int unsigned FLG_OV = 3;
   localparam int unsigned FLG_PDF = 4;
   localparam int unsigned FLG_TO = 5;
   // ***************************************************************
   // reset values
   // ***************************************************************
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [3:0] ARITH_RST = 4'h0;
endpackage : bdm_pkg

// *** bdm_mem_if.sv ***
// carrier between the control logic and the general ram
`timescale 1ns/10ps
interface bdm_mem_if;
   logic [9:0] addr;
   logic we;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport ctrl (output addr, output we, output wdata, input rdata);
   modport ram (input addr, input we, input wdata, output rdata);
endinterface : bdm_mem_if

// *** bdm_gpr_ram.sv ***
// general purpose ram, eight banks of 128 bytes, registered read
`timescale 1ns/10ps
module bdm_gpr_ram (
   // clock
   input wire logic mclk,
   // access port
   bdm_mem_if.ram mem
);
   logic [7:0] store [bdm_pkg::RAM_DEPTH];
   logic [7:0] rdata_reg;

   // write and registered read
   always_ff @(posedge mclk) begin
      if (mem.we) begin
         store[mem.addr] <= mem.wdata;
      end
      rdata_reg <= store[mem.addr];
   end

   assign mem.rdata = rdata_reg;
endmodule : bdm_gpr_ram

// *** bdm_data_memory.sv ***
// banked data memory decode, indirect ports, bank select and flag register
`timescale 1ns/10ps
module bdm_data_memory (
   // clock and reset
   input wire logic mclk,
   input wire logic srst,
   // other resets
   input wire logic sys_rst,
   input wire logic rst_wdt_pd,
   // core data port
   input wire logic [7:0] cpu_addr,
   input wire logic cpu_rd,
   input wire logic cpu_wr,
   input wire logic [7:0] cpu_wdata,
   output logic [7:0] cpu_rdata,
   output logic cpu_rvalid,
   // outside special registers
   output logic [6:0] sfr_addr,
   output logic sfr_rd,
   output logic sfr_wr,
   output logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   // nonvolatile memory control register
   output logic nvm_ctl_rd,
   output logic nvm_ctl_wr,
   input wire logic [7:0] nvm_ctl_rdata,
   // alu results
   input wire logic alu_arith,
   input wire logic alu_sub,
   input wire logic [7:0] alu_a,
   input wire logic [7:0] alu_b,
   input wire logic alu_logic,
   input wire logic [7:0] alu_result,
   input wire logic alu_rot,
   input wire logic alu_rot_c,
   // system events
   input wire logic wdt_timeout,
   input wire logic halt_exec,
   input wire logic wdt_kick,
   // table read
   input wire logic tbl_done,
   input wire logic [7:0] tbl_word_hi,
   // program counter
   input wire logic [7:0] pc_low,
   output logic pc_jump,
   output logic [7:0] pc_jump_low,
   output logic pc_dummy,
   // register views
   output logic [7:0] flags_out,
   output logic [2:0] bank_out
);
   // ***************************************************************
   // state
   // ***************************************************************
   logic [7:0] ptr0_reg;
   logic [7:0] ptr1_reg;
   logic [2:0] bank_reg;
   logic [7:0] tbl_hi_reg;
   logic [3:0] arith_reg;
   logic to_reg;
   logic pdf_reg;
   logic [7:0] cpu_rdata_reg;
   logic cpu_rvalid_reg;
   logic [7:0] loc_data_reg;
   logic [1:0] src_reg;
   logic rd_pend_reg;
   logic [6:0] sfr_addr_reg;
   logic sfr_rd_reg;
   logic sfr_wr_reg;
   logic [7:0] sfr_wdata_reg;
   logic nvm_rd_reg;
   logic nvm_wr_reg;
   logic pc_jump_reg;
   logic [7:0] pc_jump_low_reg;
   logic pc_dummy_reg;
   logic [7:0] flags_out_reg;
   logic [2:0] bank_out_reg;

   bdm_mem_if mem ();

   bdm_gpr_ram u_ram (
      .mclk (mclk),
      .mem (mem)
   );

   // ***************************************************************
   // address resolution
   // ***************************************************************
   // indirect port detection on the address the core presents
   wire hit_port0 = (cpu_addr == bdm_pkg::ADDR_IND_PORT_0);
   wire hit_port1 = (cpu_addr == bdm_pkg::ADDR_IND_PORT_1);
   wire indirect = hit_port0 | hit_port1;

   // port redirects to its pointer, port 1 also takes the bank
   wire [7:0] eff_addr = hit_port0 ? ptr0_reg :
                         hit_port1 ? ptr1_reg : cpu_addr;
   wire [2:0] eff_bank = hit_port1 ? bank_reg : bdm_pkg::BANK_ZERO;

   // a pointer aimed at a port itself gives a null access
   wire null_acc = indirect &
                   ((eff_addr == bdm_pkg::ADDR_IND_PORT_0) |
                    (eff_addr == bdm_pkg::ADDR_IND_PORT_1));

   // the direct access to a port is carried by the redirect, never stored
   wire is_gpr = eff_addr[7];
   wire is_sfr = ~eff_addr[7] & ~null_acc;

   // own special registers, same in every bank
   wire sel_ptr0 = is_sfr & (eff_addr == bdm_pkg::ADDR_IND_PTR_0);
   wire sel_ptr1 = is_sfr & (eff_addr == bdm_pkg::ADDR_IND_PTR_1);
   wire sel_bank = is_sfr & (eff_addr == bdm_pkg::ADDR_BANK_SELECT);
   wire sel_pcl = is_sfr & (eff_addr == bdm_pkg::ADDR_PROG_CNT_LOW);
   wire sel_table_high_byte = is_sfr & (eff_addr == bdm_pkg::ADDR_TABLE_HIGH);
   wire sel_flags = is_sfr & (eff_addr == bdm_pkg::ADDR_FLAGS);
   wire at_nvm = is_sfr & (eff_addr == bdm_pkg::ADDR_NVM_CONTROL);

   // nvm control only seen through port 1 with bank 1
   wire sel_nvm = at_nvm & (eff_bank == bdm_pkg::NVM_BANK);
   wire own_sel = sel_ptr0 | sel_ptr1 | sel_bank | sel_pcl | sel_table_high_byte | sel_flags;
   // every other special address lives outside, 40H outside bank 1 is empty
   wire sel_ext = is_sfr & ~own_sel & ~at_nvm;

   // bank index into the ram
   wire [9:0] ram_addr = {eff_bank, eff_addr[6:0]};

   // write strobes per target; only core write data enters, no reg-to-reg path
   wire wr_gpr = cpu_wr & is_gpr;
   wire wr_ptr0 = cpu_wr & sel_ptr0;
   wire wr_ptr1 = cpu_wr & sel_ptr1;
   wire wr_bank = cpu_wr & sel_bank;
   wire wr_pcl = cpu_wr & sel_pcl;
   wire wr_flags = cpu_wr & sel_flags;

   // strobes towards the outside registers and the nvm control register
   wire rd_ext = cpu_rd & sel_ext;
   wire wr_ext = cpu_wr & sel_ext;
   wire rd_nvm = cpu_rd & sel_nvm;
   wire wr_nvm = cpu_wr & sel_nvm;

   // bank select reset decode, a watchdog reset in power down keeps the bank
   wire bank_clear = sys_rst & ~rst_wdt_pd;
   wire bank_hold = sys_rst & rst_wdt_pd;

   assign mem.addr = ram_addr;
   assign mem.we = wr_gpr;
   assign mem.wdata = cpu_wdata;

   // ***************************************************************
   // local read value
   // ***************************************************************
   wire [7:0] bank_view = {5'b0_0000, bank_reg};
   wire [7:0] flag_view = {2'b00, to_reg, pdf_reg, arith_reg};
   wire [7:0] loc_data = sel_ptr0 ? ptr0_reg :
                         sel_ptr1 ? ptr1_reg :
                         sel_bank ? bank_view :
                         sel_pcl ? pc_low :
                         sel_table_high_byte ? tbl_hi_reg :
                         sel_flags ? flag_view : bdm_pkg::ZERO_BYTE;
   // read source: 0 local, 1 ram, 2 outside register, 3 nvm control
   wire [1:0] src = is_gpr ? 2'd1 :
                    sel_ext ? 2'd2 :
                    sel_nvm ? 2'd3 : 2'd0;

   // ***************************************************************
   // flag computation
   // ***************************************************************
   // subtract is add of inverted operand plus one, carry means no borrow
   wire [7:0] b_op = alu_sub ? ~alu_b : alu_b;
   wire cin = alu_sub;
   wire [4:0] lo_sum = {1'b0, alu_a[3:0]} + {1'b0, b_op[3:0]} + {4'h0, cin};
   wire [7:0] low7_sum = {1'b0, alu_a[6:0]} + {1'b0, b_op[6:0]} + {7'h00, cin};
   wire [8:0] full_sum = {1'b0, alu_a} + {1'b0, b_op} + {8'h00, cin};
   wire c_out = full_sum[8];
   wire ac_out = lo_sum[4];
   wire c_into_msb = low7_sum[7];
   wire ov_out = c_into_msb ^ c_out;
   wire z_arith = (full_sum[7:0] == bdm_pkg::ZERO_BYTE);
   wire z_logic = (alu_result == bdm_pkg::ZERO_BYTE);

   // next arithmetic flags; a core write to the register takes priority
   logic [3:0] arith_next;
   always_comb begin
      arith_next = arith_reg;
      if (alu_arith) begin
         arith_next[bdm_pkg::FLG_C] = c_out;
         arith_next[bdm_pkg::FLG_AC] = ac_out;
         arith_next[bdm_pkg::FLG_Z] = z_arith;
         arith_next[bdm_pkg::FLG_OV] = ov_out;
      end else if (alu_logic) begin
         arith_next[bdm_pkg::FLG_Z] = z_logic;
      end else if (alu_rot) begin
         arith_next[bdm_pkg::FLG_C] = alu_rot_c;
      end
      if (wr_flags) begin
         arith_next = cpu_wdata[3:0];
      end
   end

   // system flags: set wins over clear in the same cycle
   wire to_clear = wdt_kick | halt_exec;
   wire to_next = wdt_timeout ? 1'b1 :
                  to_clear ? 1'b0 : to_reg;
   wire pdf_next = halt_exec ? 1'b1 :
                   wdt_kick ? 1'b0 : pdf_reg;

   // value the flag register holds after this edge
   wire [7:0] flags_next = {2'b00, to_next, pdf_next, arith_next};

   // ***************************************************************
   // registers
   // ***************************************************************
   // memory pointers
   always_ff @(posedge mclk) begin
      if (srst) begin
         ptr0_reg <= bdm_pkg::ZERO_BYTE;
         ptr1_reg <= bdm_pkg::ZERO_BYTE;
      end else begin
         if (wr_ptr0) begin
            ptr0_reg <= cpu_wdata;
         end
         if (wr_ptr1) begin
            ptr1_reg <= cpu_wdata;
         end
      end
   end

   // bank select, kept by a watchdog reset in power down
   always_ff @(posedge mclk) begin
      if (srst) begin
         bank_reg <= bdm_pkg::BANK_ZERO;
      end else if (bank_clear) begin
         bank_reg <= bdm_pkg::BANK_ZERO;
      end else if (bank_hold) begin
         bank_reg <= bank_reg;
      end else if (wr_bank) begin
         bank_reg <= cpu_wdata[2:0];
      end
   end

   // table high byte from the fetched word
   always_ff @(posedge mclk) begin
      if (srst) begin
         tbl_hi_reg <= bdm_pkg::ZERO_BYTE;
      end else if (tbl_done) begin
         tbl_hi_reg <= tbl_word_hi;
      end
   end

   // flag register; nothing here pushes it on call or interrupt
   always_ff @(posedge mclk) begin
      if (srst) begin
         arith_reg <= bdm_pkg::ARITH_RST;
         to_reg <= 1'b0;
         pdf_reg <= 1'b0;
      end else begin
         arith_reg <= arith_next;
         to_reg <= to_next;
         pdf_reg <= pdf_next;
      end
   end

   // pc low jump request and the dummy cycle after it
   always_ff @(posedge mclk) begin
      if (srst) begin
         pc_jump_reg <= 1'b0;
         pc_jump_low_reg <= bdm_pkg::ZERO_BYTE;
         pc_dummy_reg <= 1'b0;
      end else begin
         pc_jump_reg <= wr_pcl;
         if (wr_pcl) begin
            pc_jump_low_reg <= cpu_wdata;
         end
         pc_dummy_reg <= pc_jump_reg;
      end
   end

   // outside register strobes
   always_ff @(posedge mclk) begin
      if (srst) begin
         sfr_addr_reg <= 7'h00;
         sfr_rd_reg <= 1'b0;
         sfr_wr_reg <= 1'b0;
         sfr_wdata_reg <= bdm_pkg::ZERO_BYTE;
         nvm_rd_reg <= 1'b0;
         nvm_wr_reg <= 1'b0;
      end else begin
         sfr_addr_reg <= eff_addr[6:0];
         sfr_rd_reg <= rd_ext;
         sfr_wr_reg <= wr_ext;
         sfr_wdata_reg <= cpu_wdata;
         nvm_rd_reg <= rd_nvm;
         nvm_wr_reg <= wr_nvm;
      end
   end

   // read pipeline stage one
   always_ff @(posedge mclk) begin
      if (srst) begin
         rd_pend_reg <= 1'b0;
         src_reg <= 2'd0;
         loc_data_reg <= bdm_pkg::ZERO_BYTE;
      end else begin
         rd_pend_reg <= cpu_rd;
         src_reg <= src;
         loc_data_reg <= loc_data;
      end
   end

   // read pipeline stage two, picks the source
   wire [7:0] rd_mux = (src_reg == 2'd1) ? mem.rdata :
                       (src_reg == 2'd2) ? sfr_rdata :
                       (src_reg == 2'd3) ? nvm_ctl_rdata : loc_data_reg;
   always_ff @(posedge mclk) begin
      if (srst) begin
         cpu_rdata_reg <= bdm_pkg::ZERO_BYTE;
         cpu_rvalid_reg <= 1'b0;
      end else begin
         cpu_rvalid_reg <= rd_pend_reg;
         if (rd_pend_reg) begin
            cpu_rdata_reg <= rd_mux;
         end
      end
   end

   // register views for the core
   always_ff @(posedge mclk) begin
      if (srst) begin
         flags_out_reg <= bdm_pkg::ZERO_BYTE;
         bank_out_reg <= bdm_pkg::BANK_ZERO;
      end else begin
         flags_out_reg <= flags_next;
         bank_out_reg <= bank_reg;
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   assign cpu_rdata = cpu_rdata_reg;
   assign cpu_rvalid = cpu_rvalid_reg;
   assign sfr_addr = sfr_addr_reg;
   assign sfr_rd = sfr_rd_reg;
   assign sfr_wr = sfr_wr_reg;
   assign sfr_wdata = sfr_wdata_reg;
   assign nvm_ctl_rd = nvm_rd_reg;
   assign nvm_ctl_wr = nvm_wr_reg;
   assign pc_jump = pc_jump_reg;
   assign pc_jump_low = pc_jump_low_reg;
   assign pc_dummy = pc_dummy_reg;
   assign flags_out = flags_out_reg;
   assign bank_out = bank_out_reg;
endmodule : bdm_data_memory

// *** bdm_sfr_model.sv ***
// model of the outside special registers and the nvm control register
`timescale 1ns/10ps
module bdm_sfr_model (
   // clock
   input wire logic mclk,
   // outside special registers
   input wire logic [6:0] sfr_addr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   // nvm control register
   input wire logic nvm_ctl_rd,
   input wire logic nvm_ctl_wr,
   output logic [7:0] nvm_ctl_rdata
);
   logic [7:0] nvm_reg = 8'h00;
   logic [7:0] sfr_val;
   // answer only while selected, inverted junk otherwise
   assign sfr_val = {1'b1, sfr_addr} ^ 8'h5A;
   assign sfr_rdata = sfr_rd ? sfr_val : ~sfr_val;
   assign nvm_ctl_rdata = nvm_ctl_rd ? nvm_reg : ~nvm_reg;
   // nvm control storage
   always @(posedge mclk) begin
      if (nvm_ctl_wr) begin
         nvm_reg <= sfr_wdata;
      end
   end
endmodule : bdm_sfr_model

// *** bdm_checker.sv ***
// port checker for the banked data memory block
`timescale 1ns/10ps
module bdm_checker (
   // clock and resets
   input wire logic mclk,
   input wire logic srst,
   input wire logic sys_rst,
   input wire logic rst_wdt_pd,
   // core port
   input wire logic [7:0] cpu_addr,
   input wire logic cpu_rd,
   input wire logic cpu_wr,
   input wire logic [7:0] cpu_wdata,
   input wire logic cpu_rvalid,
   // alu and events
   input wire logic alu_arith,
   input wire logic alu_sub,
   input wire logic [7:0] alu_a,
   input wire logic [7:0] alu_b,
   input wire logic wdt_timeout,
   input wire logic halt_exec,
   input wire logic wdt_kick,
   // outputs watched
   input logic pc_jump,
   input logic [7:0] pc_jump_low,
   input logic pc_dummy,
   input logic [7:0] flags_out,
   input logic [2:0] bank_out
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   // expected arithmetic flags
   wire [7:0] opb = alu_sub ? ~alu_b : alu_b;
   wire [8:0] sum = {1'b0, alu_a} + {1'b0, opb} + {8'h00, alu_sub};
   wire [4:0] lo = {1'b0, alu_a[3:0]} + {1'b0, opb[3:0]} + {4'h0, alu_sub};
   wire [7:0] c7 = {1'b0, alu_a[6:0]} + {1'b0, opb[6:0]} + {7'h00, alu_sub};
   wire [3:0] arith_exp = {c7[7] ^ sum[8], sum[7:0] == 8'h00, lo[4], sum[8]};
   wire flag_wr = cpu_wr && cpu_addr == bdm_pkg::ADDR_FLAGS;
   wire no_evt = !wdt_timeout && !halt_exec && !wdt_kick;
   read_latency_a: assert property (cpu_rd |-> ##2 cpu_rvalid)
      else $error("read answer late");
   pc_jump_a: assert property (cpu_wr && cpu_addr == bdm_pkg::ADDR_PROG_CNT_LOW
      |=> pc_jump && pc_jump_low == $past(cpu_wdata)) else $error("no jump");
   pc_dummy_a: assert property (pc_jump |=> pc_dummy) else $error("no dummy");
   flag_high_a: assert property (flags_out[7:6] == 2'b00)
      else $error("flag top bits set");
   arith_flags_a: assert property (alu_arith && !flag_wr
      |=> flags_out[3:0] == $past(arith_exp)) else $error("arith flags wrong");
   timeout_set_a: assert property (wdt_timeout |=> flags_out[5])
      else $error("timeout flag not set");
   halt_flags_a: assert property (halt_exec && !wdt_timeout
      |=> flags_out[5:4] == 2'b01) else $error("halt flags wrong");
   kick_flags_a: assert property (wdt_kick && !halt_exec && !wdt_timeout
      |=> flags_out[5:4] == 2'b00) else $error("kick flags wrong");
   flag_write_a: assert property (flag_wr && no_evt |=> $stable(flags_out[5:4]))
      else $error("flag write hit system bits");
   bank_write_a: assert property (cpu_wr && cpu_addr == bdm_pkg::ADDR_BANK_SELECT
      && !sys_rst |=> ##1 bank_out == $past(cpu_wdata[2:0], 2)) else $error("bank wrong");
   bank_reset_a: assert property (sys_rst && !rst_wdt_pd && !cpu_wr
      |=> ##1 bank_out == 3'h0) else $error("bank not reset");
   bank_keep_a: assert property (sys_rst && rst_wdt_pd && !cpu_wr
      |=> ##1 $stable(bank_out)) else $error("bank not kept");
   // main scenarios reached
   cover property (sys_rst && rst_wdt_pd);
   cover property (alu_arith && alu_sub);
   cover property (pc_dummy);
endmodule : bdm_checker
bind bdm_data_memory bdm_checker i_chk (.*);

// *** tb_top.sv ***
// self-checking testbench for the banked data memory block
`timescale 1ns/10ps
module tb_top;
   logic mclk, srst, sys_rst, rst_wdt_pd, cpu_rd, cpu_wr, cpu_rvalid;
   logic [7:0] cpu_addr, cpu_wdata, cpu_rdata, sfr_wdata, sfr_rdata, nvm_ctl_rdata;
   logic [6:0] sfr_addr;
   logic sfr_rd, sfr_wr, nvm_ctl_rd, nvm_ctl_wr, pc_jump, pc_dummy, tbl_done;
   logic alu_arith, alu_sub, alu_logic, alu_rot, alu_rot_c, wdt_timeout, halt_exec, wdt_kick;
   logic [7:0] alu_a, alu_b, alu_result, tbl_word_hi, pc_low, pc_jump_low, flags_out;
   logic [2:0] bank_out;
   int n_errors = 0;
   int cmp_count = 0;
   bdm_data_memory i_dut (.*);
   bdm_sfr_model i_sfr (.*);
   // clock and watchdog
   always #2.5 mclk = ~mclk;
   initial begin
      #20000;
      n_errors++;
      test_done();
   end
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : test_done
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      #1;
      cpu_addr = a;
      cpu_wdata = d;
      cpu_wr = 1'b1;
      @(posedge mclk);
      #1;
      cpu_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk);
      #1;
      cpu_addr = a;
      cpu_rd = 1'b1;
      @(posedge mclk);
      #1;
      cpu_rd = 1'b0;
      @(posedge mclk);
      #1;
      chk("rvalid", {7'h00, cpu_rvalid}, 8'h01);
      chk("rdata", cpu_rdata, e);
   endtask : rd
   // pulse {tbl_done, kick, halt, timeout} or alu {rot, logic, sub, arith}
   task automatic evt(input logic [3:0] k);
      @(posedge mclk);
      #1;
      {tbl_done, wdt_kick, halt_exec, wdt_timeout} = k;
      @(posedge mclk);
      #1;
      {tbl_done, wdt_kick, halt_exec, wdt_timeout} = 4'h0;
   endtask : evt
   task automatic alu(input logic [3:0] k, input logic [7:0] x, input logic [7:0] y);
      @(posedge mclk);
      #1;
      {alu_rot, alu_logic, alu_sub, alu_arith} = k;
      alu_a = x;
      alu_b = y;
      alu_result = x;
      alu_rot_c = y[0];
      @(posedge mclk);
      #1;
      {alu_rot, alu_logic, alu_sub, alu_arith} = 4'h0;
   endtask : alu
   task automatic t_reset;
      chk("flags_out", flags_out, 8'h00);
      chk("bank_out", {5'h00, bank_out}, 8'h00);
      rd(bdm_pkg::ADDR_FLAGS, 8'h00);
      wr(bdm_pkg::ADDR_BANK_SELECT, 8'hFF);
      rd(bdm_pkg::ADDR_BANK_SELECT, 8'h07);
      $display("test reset done");
   endtask : t_reset
   task automatic t_banks;
      wr(bdm_pkg::ADDR_IND_PTR_1, 8'h85);
      for (int k = 0; k < 8; k++) begin
         wr(bdm_pkg::ADDR_BANK_SELECT, k[7:0]);
         wr(bdm_pkg::ADDR_IND_PORT_1, 8'hA0 + k[7:0]);
      end
      for (int k = 0; k < 8; k++) begin
         wr(bdm_pkg::ADDR_BANK_SELECT, k[7:0]);
         rd(bdm_pkg::ADDR_IND_PORT_1, 8'hA0 + k[7:0]);
      end
      rd(8'h85, 8'hA0);
      wr(bdm_pkg::ADDR_IND_PTR_0, 8'h85);
      rd(bdm_pkg::ADDR_IND_PORT_0, 8'hA0);
      wr(8'h85, 8'h5A);
      rd(bdm_pkg::ADDR_IND_PORT_1, 8'hA7);
      rd(bdm_pkg::ADDR_IND_PORT_0, 8'h5A);
      $display("test banks done");
   endtask : t_banks
   task automatic t_null;
      wr(bdm_pkg::ADDR_IND_PTR_1, bdm_pkg::ADDR_IND_PORT_1);
      wr(bdm_pkg::ADDR_IND_PORT_1, 8'h66);
      rd(bdm_pkg::ADDR_IND_PORT_1, 8'h00);
      wr(bdm_pkg::ADDR_IND_PTR_0, bdm_pkg::ADDR_IND_PORT_0);
      rd(bdm_pkg::ADDR_IND_PORT_0, 8'h00);
      rd(bdm_pkg::ADDR_IND_PTR_1, bdm_pkg::ADDR_IND_PORT_1);
      $display("test null done");
   endtask : t_null
   task automatic t_sfr;
      rd(8'h20, 8'hFA);
      wr(8'h20, 8'h3C);
      chk("sfr_wr", {7'h00, sfr_wr}, 8'h01);
      chk("sfr_addr", {1'b0, sfr_addr}, 8'h20);
      chk("sfr_wdata", sfr_wdata, 8'h3C);
      wr(bdm_pkg::ADDR_BANK_SELECT, 8'h01);
      wr(bdm_pkg::ADDR_IND_PTR_1, bdm_pkg::ADDR_NVM_CONTROL);
      wr(bdm_pkg::ADDR_IND_PORT_1, 8'h15);
      rd(bdm_pkg::ADDR_IND_PORT_1, 8'h15);
      rd(bdm_pkg::ADDR_NVM_CONTROL, 8'h00);
      wr(bdm_pkg::ADDR_BANK_SELECT, 8'h02);
      rd(bdm_pkg::ADDR_IND_PORT_1, 8'h00);
      $display("test sfr done");
   endtask : t_sfr
   task automatic t_prog;
      wr(bdm_pkg::ADDR_PROG_CNT_LOW, 8'hC4);
      chk("pc_jump", {7'h00, pc_jump}, 8'h01);
      @(posedge mclk);
      #1;
      chk("pc_dummy", {7'h00, pc_dummy}, 8'h01);
      chk("pc_jump", {7'h00, pc_jump}, 8'h00);
      rd(bdm_pkg::ADDR_PROG_CNT_LOW, 8'h37);
      chk("pc_jump_low", pc_jump_low, 8'hC4);
      tbl_word_hi = 8'h9C;
      evt(4'h8);
      rd(bdm_pkg::ADDR_TABLE_HIGH, 8'h9C);
      $display("test prog done");
   endtask : t_prog
   task automatic t_flags;
      alu(4'h1, 8'h7F, 8'h01);
      rd(bdm_pkg::ADDR_FLAGS, 8'h0A);
      alu(4'h4, 8'h00, 8'h00);
      alu(4'h8, 8'h00, 8'h01);
      rd(bdm_pkg::ADDR_FLAGS, 8'h0F);
      alu(4'h3, 8'h10, 8'h10);
      rd(bdm_pkg::ADDR_FLAGS, 8'h07);
      alu(4'h4, 8'h55, 8'h00);
      alu(4'h8, 8'h00, 8'h00);
      rd(bdm_pkg::ADDR_FLAGS, 8'h02);
      evt(4'h1);
      rd(bdm_pkg::ADDR_FLAGS, 8'h22);
      evt(4'h2);
      rd(bdm_pkg::ADDR_FLAGS, 8'h12);
      wr(bdm_pkg::ADDR_FLAGS, 8'hFF);
      rd(bdm_pkg::ADDR_FLAGS, 8'h1F);
      evt(4'h4);
      rd(bdm_pkg::ADDR_FLAGS, 8'h0F);
      $display("test flags done");
   endtask : t_flags
   task automatic t_sysrst(input logic pd, input logic [7:0] e);
      wr(bdm_pkg::ADDR_BANK_SELECT, 8'h05);
      @(posedge mclk);
      #1;
      {sys_rst, rst_wdt_pd} = {1'b1, pd};
      @(posedge mclk);
      #1;
      sys_rst = 1'b0;
      rd(bdm_pkg::ADDR_BANK_SELECT, e);
      $display("test other reset done");
   endtask : t_sysrst
   // main sequence
   initial begin
      {mclk, srst, sys_rst, rst_wdt_pd, cpu_rd, cpu_wr, tbl_done} = 7'h20;
      {alu_arith, alu_sub, alu_logic, alu_rot, alu_rot_c} = 5'h00;
      {wdt_timeout, halt_exec, wdt_kick} = 3'h0;
      {cpu_addr, cpu_wdata, alu_a, alu_b, alu_result} = 40'h0000_0000_00;
      tbl_word_hi = 8'h00;
      pc_low = 8'h37;
      repeat (5) @(posedge mclk);
      #1;
      srst = 1'b0;
      t_reset();
      t_banks();
      t_null();
      t_sfr();
      t_prog();
      t_flags();
      t_sysrst(1'b1, 8'h05);
      t_sysrst(1'b0, 8'h00);
      test_done();
   end
endmodule : tb_top
